/* rtl/core_memory_access_arbiter.sv */
// core memory access arbiter with block transfer control word logic
//
// Contract
// - Fourteen output channels numbered 0 to octal 15; 0 and 1 intercomputer.
// - Simultaneous output requests: highest channel number served first.
// - Each input channel has a 30-line gated path; highest channel first.
// - Input words go from channel lines straight into memory data path.
// - Rank: clock, ext int, out mon, in mon, out, in, ic out.
// - Same-type requests granted in descending channel number.
// - Both intercomputer channels requesting: in and out grants alternate; ext int and monitor grants go to channel 1.
// - Memory holds 32768 30-bit words; read loads the holding register.
// - Holding register splits into independent upper and lower halves.
// - Reads destroy; data restored within an eight microsecond cycle.
// - Restore may add one to lower half of word.
// - Equal control word halves raise the block transfer end signal.
// - Each access starts by loading and decoding the 15-bit address.
// - Manual disable stops clock advance requests; resumes when re-enabled.
// - General output holding register feeds three groups of line drivers.
// - Intercomputer output holding register feeds the two ic channels.
// - External requests pace transfers; each answered once access granted.
`timescale 1ns/100ps
`default_nettype none

module core_memory_access_arbiter #(
  parameter int RTC_TICK_CLKS = mem_arb_pkg::RTC_TICK_CLKS
) (
  input  wire logic                        clk_i,         // 100 MHz clock
  input  wire logic                        resetn_i,      // async reset
  input  wire mem_arb_pkg::req_bundle_type req_i,         // request levels
  input  wire mem_arb_pkg::chan_words_type in_data_i,     // input lines
  input  wire logic                        rtc_disable_i, // manual rtc off
  output logic                             idle_o,        // no access
  output mem_arb_pkg::req_bundle_type      ack_o,         // grant answers
  output logic [mem_arb_pkg::NUM_CH-1:0]   term_o,        // block end
  output mem_arb_pkg::drv_words_type       line_drv_o,    // driver groups
  output logic [mem_arb_pkg::WORD_W-1:0]   ic_out_o,      // ic out word
  output logic [mem_arb_pkg::WORD_W-1:0]   entry_word_o,  // int entrance
  output logic                             entry_valid_o  // entrance pulse
);
  import mem_arb_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    req_bundle_type        req_s1;
    req_bundle_type        req_s2;
    chan_words_type        dat_s1;
    chan_words_type        dat_s2;
    logic                  dis_s1;
    logic                  dis_s2;
    logic [RTC_DIV_W-1:0]  rtc_div;
    logic                  rtc_pend;
    phase_type             phase;
    logic [CNT_W-1:0]      cnt;
    req_kind_type          kind;
    logic [CH_W-1:0]       chan;
    logic [ADDR_W-1:0]     saddr;
    logic [WORD_W-1:0]     z;
    logic [ADDR_W-1:0]     data_addr;
    logic                  last;
    logic                  alt_out;
    logic                  alt_in;
    logic                  idle;
    req_bundle_type        ack;
    logic [NUM_CH-1:0]     term;
    logic [WORD_W-1:0]     gen_out;
    logic [WORD_W-1:0]     ic_out;
    logic [WORD_W-1:0]     entry;
    logic                  entry_valid;
  } state_type;

  state_type s;
  state_type next_s;

  logic [WORD_W-1:0] mem [MEM_DEPTH];
  logic              mem_we;
  logic [WORD_W-1:0] mem_wdata;
  logic [WORD_W-1:0] mem_rdata;

  // ----------------------------------------------------------------
  // channel picker: highest number wins, ic pair alternates
  // ----------------------------------------------------------------
  function automatic logic [CH_W:0] pick(input logic [NUM_CH-1:0] v,
                                         input logic              alt);
    logic [CH_W:0] r;
    r = '0;
    for (int i = IC_CH_COUNT; i < NUM_CH; i++) begin
      if (v[i]) begin
        r = {1'b1, CH_W'(i)};
      end
    end
    if (r[CH_W] == 1'b0) begin
      if (v[1] && v[0]) begin
        r = {1'b1, alt ? 4'h0 : 4'h1};
      end else if (v[1]) begin
        r = {1'b1, 4'h1};
      end else if (v[0]) begin
        r = {1'b1, 4'h0};
      end
    end
    return r;
  endfunction

  function automatic logic [NUM_CH-1:0] onehot(input logic [CH_W-1:0] c);
    logic [NUM_CH-1:0] r;
    r = '0;
    r[c] = 1'b1;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [CH_W:0]     p_ext;
    logic [CH_W:0]     p_om;
    logic [CH_W:0]     p_im;
    logic [CH_W:0]     p_on;
    logic [CH_W:0]     p_in;
    logic [CH_W:0]     p_ic;
    logic [HALF_W-1:0] low_inc;
    p_ext   = pick(s.req_s2.ext_int, 1'b0);
    p_om    = pick(s.req_s2.out_mon, 1'b0);
    p_im    = pick(s.req_s2.in_mon, 1'b0);
    p_on    = pick({s.req_s2.out_req[NUM_CH-1:IC_CH_COUNT], 2'b00}, 1'b0);
    p_in    = pick(s.req_s2.in_req, s.alt_in);
    p_ic    = pick({12'h000, s.req_s2.out_req[IC_CH_COUNT-1:0]},
                   s.alt_out);
    low_inc = s.z[LOWER_LSB +: HALF_W] + 15'h0001;
    next_s             = s;
    next_s.req_s1      = req_i;
    next_s.req_s2      = s.req_s1;
    next_s.dat_s1      = in_data_i;
    next_s.dat_s2      = s.dat_s1;
    next_s.dis_s1      = rtc_disable_i;
    next_s.dis_s2      = s.dis_s1;
    next_s.ack         = '0;
    next_s.term        = '0;
    next_s.entry_valid = 1'b0;
    mem_we             = 1'b0;
    mem_wdata          = '0;

    // real-time clock advance tick, frozen while disabled
    if (!s.dis_s2) begin
      if (s.rtc_div == RTC_DIV_W'(RTC_TICK_CLKS - 1)) begin
        next_s.rtc_div  = '0;
        next_s.rtc_pend = 1'b1;
      end else begin
        next_s.rtc_div = s.rtc_div + 20'h00001;
      end
    end

    case (s.phase)
      PH_IDLE: begin
        next_s.cnt   = '0;
        next_s.phase = PH_CTRL;
        next_s.idle  = 1'b0;
        if (s.rtc_pend && !s.dis_s2) begin
          next_s.kind     = KIND_RTC;
          next_s.chan     = '0;
          next_s.saddr    = RTC_WORD_ADDR;
          next_s.rtc_pend = (s.rtc_div == RTC_DIV_W'(RTC_TICK_CLKS - 1));
        end else if (p_ext[CH_W]) begin
          next_s.kind  = KIND_EXT_INT;
          next_s.chan  = p_ext[CH_W-1:0];
          next_s.saddr = EXT_INT_BASE + ADDR_W'(p_ext[CH_W-1:0]);
        end else if (p_om[CH_W]) begin
          next_s.kind  = KIND_OUT_MON;
          next_s.chan  = p_om[CH_W-1:0];
          next_s.saddr = OUT_MON_BASE + ADDR_W'(p_om[CH_W-1:0]);
        end else if (p_im[CH_W]) begin
          next_s.kind  = KIND_IN_MON;
          next_s.chan  = p_im[CH_W-1:0];
          next_s.saddr = IN_MON_BASE + ADDR_W'(p_im[CH_W-1:0]);
        end else if (p_on[CH_W]) begin
          next_s.kind  = KIND_OUT_NORM;
          next_s.chan  = p_on[CH_W-1:0];
          next_s.saddr = OUT_CW_BASE + ADDR_W'(p_on[CH_W-1:0]);
        end else if (p_in[CH_W]) begin
          next_s.kind  = KIND_IN;
          next_s.chan  = p_in[CH_W-1:0];
          next_s.saddr = IN_CW_BASE + ADDR_W'(p_in[CH_W-1:0]);
          if (p_in[CH_W-1:0] < CH_W'(IC_CH_COUNT)) begin
            next_s.alt_in = (p_in[CH_W-1:0] == 4'h1);
          end
        end else if (p_ic[CH_W]) begin
          next_s.kind    = KIND_OUT_IC;
          next_s.chan    = p_ic[CH_W-1:0];
          next_s.saddr   = OUT_CW_BASE + ADDR_W'(p_ic[CH_W-1:0]);
          next_s.alt_out = (p_ic[CH_W-1:0] == 4'h1);
        end else begin
          next_s.phase = PH_IDLE;
          next_s.idle  = 1'b1;
        end
      end
      PH_CTRL, PH_DATA: begin
        next_s.cnt = s.cnt + 10'h001;
        if (s.cnt == READ_AT) begin
          next_s.z  = mem_rdata;
          mem_we    = 1'b1;
          mem_wdata = '0;
        end
        if (s.cnt == MODIFY_AT) begin
          if (s.phase == PH_CTRL) begin
            if (s.kind != KIND_EXT_INT && s.kind != KIND_OUT_MON &&
                s.kind != KIND_IN_MON) begin
              next_s.z[LOWER_LSB +: HALF_W] = low_inc;
              next_s.data_addr = s.z[LOWER_LSB +: HALF_W];
              next_s.last = (s.z[UPPER_LSB +: HALF_W] == low_inc);
            end
          end else if (s.kind == KIND_IN) begin
            next_s.z = s.dat_s2[s.chan];
          end
        end
        if (s.cnt == RESTORE_AT) begin
          mem_we       = 1'b1;
          mem_wdata    = s.z;
          next_s.cnt   = '0;
          next_s.phase = PH_SETTLE;
          if (s.phase == PH_DATA) begin
            if (s.kind == KIND_OUT_NORM) begin
              next_s.gen_out = s.z;
              next_s.ack.out_req = onehot(s.chan);
            end else if (s.kind == KIND_OUT_IC) begin
              next_s.ic_out = s.z;
              next_s.ack.out_req = onehot(s.chan);
            end else begin
              next_s.ack.in_req = onehot(s.chan);
            end
            if (s.last) begin
              next_s.term = onehot(s.chan);
            end
          end else if (s.kind == KIND_EXT_INT) begin
            next_s.entry       = s.z;
            next_s.entry_valid = 1'b1;
            next_s.ack.ext_int = onehot(s.chan);
          end else if (s.kind == KIND_OUT_MON) begin
            next_s.entry       = s.z;
            next_s.entry_valid = 1'b1;
            next_s.ack.out_mon = onehot(s.chan);
          end else if (s.kind == KIND_IN_MON) begin
            next_s.entry       = s.z;
            next_s.entry_valid = 1'b1;
            next_s.ack.in_mon  = onehot(s.chan);
          end else if (s.kind != KIND_RTC) begin
            next_s.phase = PH_DATA;
            next_s.saddr = s.data_addr;
          end
        end
      end
      PH_SETTLE: begin
        next_s.cnt = s.cnt + 10'h001;
        if (s.cnt == SETTLE_AT) begin
          next_s.phase = PH_IDLE;
          next_s.idle  = 1'b1;
        end
      end
      default: begin
        next_s.phase = PH_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers and core array
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign mem_rdata = mem[s.saddr];

  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem[s.saddr] <= mem_wdata;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign idle_o        = s.idle;
  assign ack_o         = s.ack;
  assign term_o        = s.term;
  assign line_drv_o    = {DRV_GROUPS{s.gen_out}};
  assign ic_out_o      = s.ic_out;
  assign entry_word_o  = s.entry;
  assign entry_valid_o = s.entry_valid;

endmodule
`default_nettype wire

/* rtl/mem_arb_pkg.sv */
// shared constants and types for the core memory access arbiter
package mem_arb_pkg;

  // ----------------------------------------------------------------
  // word, channel and memory geometry
  // ----------------------------------------------------------------
  localparam int NUM_CH       = 14;
  localparam int CH_W         = 4;
  localparam int WORD_W       = 30;
  localparam int HALF_W       = 15;
  localparam int ADDR_W       = 15;
  localparam int MEM_DEPTH    = 32768;
  localparam int IC_CH_COUNT  = 2;
  localparam int DRV_GROUPS   = 3;
  localparam int CH_PER_GROUP = 4;
  localparam int LOWER_LSB    = 0;
  localparam int UPPER_LSB    = 15;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int CYCLE_TIME_NS  = 8000;
  localparam int CYCLE_CLKS     = CYCLE_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W          = 10;
  localparam logic [CNT_W-1:0] READ_AT    = 10'h001;
  localparam logic [CNT_W-1:0] MODIFY_AT  = CNT_W'(CYCLE_CLKS / 2);
  localparam logic [CNT_W-1:0] RESTORE_AT = CNT_W'(CYCLE_CLKS - 1);
  localparam logic [CNT_W-1:0] SETTLE_AT  = 10'h004;
  localparam int RTC_TICK_NS    = 1000000;
  localparam int RTC_TICK_CLKS  = RTC_TICK_NS / CLK_PERIOD_NS;
  localparam int RTC_DIV_W      = 20;

  // ----------------------------------------------------------------
  // fixed memory locations of control and entrance words
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] RTC_WORD_ADDR = 15'h0000;
  localparam logic [ADDR_W-1:0] EXT_INT_BASE  = 15'h0010;
  localparam logic [ADDR_W-1:0] OUT_MON_BASE  = 15'h0020;
  localparam logic [ADDR_W-1:0] IN_MON_BASE   = 15'h0030;
  localparam logic [ADDR_W-1:0] OUT_CW_BASE   = 15'h0040;
  localparam logic [ADDR_W-1:0] IN_CW_BASE    = 15'h0050;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    KIND_RTC, KIND_EXT_INT, KIND_OUT_MON, KIND_IN_MON,
    KIND_OUT_NORM, KIND_IN, KIND_OUT_IC
  } req_kind_type;

  typedef enum logic [1:0] {
    PH_IDLE, PH_CTRL, PH_DATA, PH_SETTLE
  } phase_type;

  typedef struct packed {
    logic [NUM_CH-1:0] ext_int;
    logic [NUM_CH-1:0] out_mon;
    logic [NUM_CH-1:0] in_mon;
    logic [NUM_CH-1:0] out_req;
    logic [NUM_CH-1:0] in_req;
  } req_bundle_type;

  typedef logic [NUM_CH-1:0][WORD_W-1:0] chan_words_type;
  typedef logic [DRV_GROUPS-1:0][WORD_W-1:0] drv_words_type;

endpackage

/* testbench/core_memory_access_arbiter_chk.sv */
// port-level assertion checker for the core memory access arbiter
`timescale 1ns/100ps
`default_nettype none

module core_memory_access_arbiter_chk
  import mem_arb_pkg::*;
(
  input wire logic                      clk_i,        // clock
  input wire logic                      resetn_i,     // async reset
  input wire req_bundle_type            req_i,        // request levels
  input wire logic                      idle_o,       // no access
  input wire req_bundle_type            ack_o,        // grant answers
  input wire logic [NUM_CH-1:0]         term_o,       // block end
  input wire drv_words_type             line_drv_o,   // driver groups
  input wire logic                      entry_valid_o // entrance pulse
);
  // ----------------------------------------------------------------
  // busy span counter
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] busy_cnt;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_cnt <= '0;
    end else if (idle_o) begin
      busy_cnt <= '0;
    end else if (busy_cnt != '1) begin
      busy_cnt <= busy_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  property p_one_grant; $onehot0(ack_o); endproperty
  a_one_grant: assert property (p_one_grant)
    else $error("more than one grant at once");
  property p_grant_pulse; ack_o != '0 |=> ack_o == '0; endproperty
  a_grant_pulse: assert property (p_grant_pulse)
    else $error("grant answer longer than one cycle");
  property p_grant_busy; ack_o != '0 |-> !idle_o && busy_cnt >= 10'h316;
  endproperty
  a_grant_busy: assert property (p_grant_busy)
    else $error("answer before a full memory cycle");
  property p_settle; ack_o != '0 |-> ##[4:7] idle_o; endproperty
  a_settle: assert property (p_settle)
    else $error("access not released after answer");
  property p_entry;
    entry_valid_o == |{ack_o.ext_int, ack_o.out_mon, ack_o.in_mon};
  endproperty
  a_entry: assert property (p_entry)
    else $error("entrance pulse without interrupt answer");
  property p_term; (term_o & ~(ack_o.out_req | ack_o.in_req)) === '0;
  endproperty
  a_term: assert property (p_term)
    else $error("block end without transfer answer");
  property p_drivers;
    line_drv_o[0] === line_drv_o[1] && line_drv_o[1] === line_drv_o[2];
  endproperty
  a_drivers: assert property (p_drivers)
    else $error("driver groups disagree");
  property p_take; idle_o && req_i != '0 |-> ##[1:4] !idle_o; endproperty
  a_take: assert property (p_take)
    else $error("pending request not taken");
  property p_ack_req; ack_o != '0 |-> (ack_o & req_i) == ack_o; endproperty
  a_ack_req: assert property (p_ack_req)
    else $error("answer to a channel that is not asking");
endmodule

bind core_memory_access_arbiter core_memory_access_arbiter_chk u_chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i), .idle_o(idle_o),
  .ack_o(ack_o), .term_o(term_o), .line_drv_o(line_drv_o),
  .entry_valid_o(entry_valid_o));

`default_nettype wire

/* testbench/ext_equipment.sv */
// model of the external equipment on the channel side
`timescale 1ns/100ps
`default_nettype none

module ext_equipment
  import mem_arb_pkg::*;
(
  input  wire logic           clk_i,    // clock
  input  wire logic           resetn_i, // async reset
  input  wire req_bundle_type raise_i,  // new request pulses
  input  wire req_bundle_type ack_i,    // grant answers
  output var  req_bundle_type req_o,    // request levels
  output var  chan_words_type in_data_o // input lines
);
  // requests held until answered, dropped on the answer edge
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      req_o <= '0;
    end else begin
      req_o <= (req_o & ~ack_i) | raise_i;
    end
  end

  // lines stable while asking, inverted once released
  always_comb begin
    for (int n = 0; n < NUM_CH; n++) begin
      in_data_o[n] = WORD_W'(32'h1234_5670 + n);
      if (!req_o.in_req[n]) begin
        in_data_o[n] = ~in_data_o[n];
      end
    end
  end
endmodule

`default_nettype wire

/* testbench/test_core_memory_access_arbiter.sv */
// self-checking testbench for the core memory access arbiter
`timescale 1ns/100ps
`default_nettype none

module test_core_memory_access_arbiter;
  import mem_arb_pkg::*;
  localparam int TICK = 100;
  logic              clk_i;
  logic              resetn_i;
  logic              rtc_disable_i;
  req_bundle_type    raise;
  req_bundle_type    req;
  req_bundle_type    ack;
  chan_words_type    in_data;
  logic              idle;
  logic              entry_valid;
  logic [WORD_W-1:0] ic_out;
  logic [WORD_W-1:0] entry_word;
  logic [NUM_CH-1:0] term;
  drv_words_type     drv;
  int                errors;
  int                checks;

  ext_equipment u_ext_equipment (.clk_i(clk_i), .resetn_i(resetn_i),
    .raise_i(raise), .ack_i(ack), .req_o(req), .in_data_o(in_data));
  core_memory_access_arbiter #(.RTC_TICK_CLKS(TICK))
    u_core_memory_access_arbiter (.clk_i(clk_i), .resetn_i(resetn_i),
    .req_i(req), .in_data_i(in_data), .rtc_disable_i(rtc_disable_i),
    .idle_o(idle), .ack_o(ack), .term_o(term), .line_drv_o(drv),
    .ic_out_o(ic_out), .entry_word_o(entry_word),
    .entry_valid_o(entry_valid));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task check(input logic [69:0] seen, input logic [69:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic req_bundle_type mk(input int k, input int ch);
    req_bundle_type b;
    b = '0;
    case (k)
      0: b.ext_int[ch] = 1'b1;
      1: b.out_mon[ch] = 1'b1;
      2: b.in_mon[ch] = 1'b1;
      3: b.out_req[ch] = 1'b1;
      default: b.in_req[ch] = 1'b1;
    endcase
    return b;
  endfunction

  task send(input req_bundle_type b);
    @(posedge clk_i);
    #1 raise = b;
    @(posedge clk_i);
    #1 raise = '0;
  endtask

  task wait_ack(output req_bundle_type got, output int lat);
    got = '0;
    for (lat = 0; lat < 2000 && got === '0; lat++) begin
      @(posedge clk_i);
      #1 got = ack;
    end
  endtask

  task expect_acks(input req_bundle_type exp[$]);
    req_bundle_type got;
    int lat;
    foreach (exp[i]) begin
      wait_ack(got, lat);
      check(got, exp[i]);
    end
  endtask

  // preload a core location while the arbiter leaves it alone
  task poke(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] w);
    u_core_memory_access_arbiter.mem[a] = w;
  endtask

  task t_block;
    req_bundle_type got;
    int lat;
    poke(IN_CW_BASE + 15'h0006, {15'h0201, 15'h0200});
    poke(OUT_CW_BASE + 15'h0005, {15'h0203, 15'h0200});
    poke(OUT_CW_BASE, {15'h0300, 15'h02FF});
    poke(15'h02FF, 30'h1555_AAAA);
    poke(EXT_INT_BASE + 15'h0002, 30'h0ABC_DEF0);
    send(mk(4, 6));
    wait_ack(got, lat);
    check(got, mk(4, 6));
    check(term, 14'h0040);
    send(mk(3, 5));
    wait_ack(got, lat);
    check(got, mk(3, 5));
    check(term, 14'h0000);
    check(drv[2], 30'h1234_5676);
    check({drv[1], drv[0]}, {2{30'h1234_5676}});
    send(mk(3, 0) | mk(0, 2));
    wait_ack(got, lat);
    check(got, mk(0, 2));
    check({entry_valid, entry_word}, {1'b1, 30'h0ABC_DEF0});
    wait_ack(got, lat);
    check(got, mk(3, 0));
    check({term, ic_out}, {14'h0001, 30'h1555_AAAA});
  endtask

  task results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    repeat (20) @(posedge clk_i);
    check(idle, 0);
    check(ack, '0);
    #1 resetn_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1 check(idle, 1);
  endtask

  task t_rank;
    req_bundle_type got;
    int lat;
    send(mk(0, 3) | mk(1, 5) | mk(2, 7) | mk(3, 9) | mk(4, 11) | mk(3, 1));
    wait_ack(got, lat);
    check(got, mk(0, 3));
    check(lat >= 800 && lat <= 806, 1);
    expect_acks({mk(1, 5), mk(2, 7), mk(3, 9), mk(4, 11), mk(3, 1)});
  endtask

  task t_channels;
    req_bundle_type got;
    int lat;
    send(mk(3, 13) | mk(3, 4) | mk(3, 2) | mk(4, 13) | mk(4, 6) | mk(4, 1));
    wait_ack(got, lat);
    check(got, mk(3, 13));
    check(lat >= 1600 && lat <= 1606, 1);
    expect_acks({mk(3, 4), mk(3, 2), mk(4, 13), mk(4, 6), mk(4, 1)});
  endtask

  task t_ic;
    req_bundle_type a, b, c;
    int lat;
    send(mk(3, 0) | mk(3, 1));
    wait_ack(a, lat);
    check(a === mk(3, 0) || a === mk(3, 1), 1);
    send(a);
    wait_ack(b, lat);
    check(b, (mk(3, 0) | mk(3, 1)) ^ a);
    send(b);
    wait_ack(c, lat);
    check(c, a);
    expect_acks({b});
  endtask

  task t_rtc;
    int n;
    repeat (4 * TICK) begin
      @(posedge clk_i);
      #1 check(idle, 1);
    end
    rtc_disable_i = 1'b0;
    for (n = 0; n < TICK + 20 && idle === 1'b1; n++) begin
      @(posedge clk_i);
    end
    #1 check(idle, 0);
    rtc_disable_i = 1'b1;
    repeat (820) begin
      @(posedge clk_i);
      #1 check(ack, '0);
    end
    repeat (3 * TICK) begin
      @(posedge clk_i);
      #1 check(idle, 1);
    end
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    errors++;
    results();
  end

  initial begin
    errors = 0;
    checks = 0;
    resetn_i = 1'b0;
    rtc_disable_i = 1'b1;
    raise = '0;
    t_reset();
    t_rtc();
    t_rank();
    t_channels();
    t_ic();
    t_block();
    results();
  end
endmodule

`default_nettype wire
